// ==== rtl/hsps_pkg.sv ====
// Package of constants for the hot-swap power sequencer.
package hsps_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Least time that the seated contact must be stable before rails come on.
  localparam int unsigned SEAT_DEBOUNCE_US = 100;
  localparam int unsigned SEAT_DEBOUNCE_CYC =
    (SEAT_DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 12;

  // ==========================================================================
  // Power module command codes sent to the management link
  // ==========================================================================
  localparam logic [1:0] PM_CMD_OFF = 2'h0;
  localparam logic [1:0] PM_CMD_ON = 2'h1;
  localparam logic [1:0] PM_CMD_CORE = 2'h2;
  localparam logic [1:0] PM_CMD_LEVEL = 2'h3;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [5:0] {
    HSPS_ST_EARLY = 6'h01,
    HSPS_ST_SEAT = 6'h02,
    HSPS_ST_RAMP = 6'h04,
    HSPS_ST_RUN = 6'h08,
    HSPS_ST_EXTRACT = 6'h10,
    HSPS_ST_SAFE = 6'h20
  } hsps_state_type;

endpackage

// ==== rtl/hsps_supply_sel.sv ====
// Early power or backup management power source selector.
`timescale 1ns/1ps
`default_nettype none
module hsps_supply_sel (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic early_valid_in,
  output logic early_sw_en_out,
  output logic backup_sw_en_out
);

  logic early_q;
  logic early_d;

  // ==========================================================================
  // Source choice
  // ==========================================================================
  always_comb
  begin
    early_d = early_q;
    if (clk_en_in)
    begin
      early_d = early_valid_in;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      early_q <= 1'b1;
    end
    else
    begin
      early_q <= early_d;
    end
  end

  // One flip-flop drives both switch enables, so both can never be on.
  assign early_sw_en_out = early_q;
  assign backup_sw_en_out = ~early_q;

endmodule
`default_nettype wire

// ==== rtl/hsps_top.sv ====
// Hot-swap power sequencer top level.
// Summary of operation
// - Backend rails on only after full seating.
// - Release board resets once power good.
// - Memory select may go low only when good.
// - Green LED lit while power good.
// - Command module core, level and on state.
// - Power module shuts itself down on faults.
// - Exactly one supply switch enabled at once.
// - Early power lost: switch to backup power.
// - Early power back: restore original switches.
// - Stay in reset until healthy, despite host reset.
// - Assert enumerate after insertion or before extraction.
// - Hot-swap switch starts the removal sequence.
// - Blue LED only when extraction is safe.
// - Early power onset resets controller and board.
`timescale 1ns/1ps
`default_nettype none
module hsps_top (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic seated_in,
  input wire logic power_module_good_in,
  input wire logic healthy_n_in,
  input wire logic pci_rst_n_in,
  input wire logic swap_switch_in,
  input wire logic enum_ack_in,
  input wire logic early_valid_in,
  input wire logic mem_cs_n_in,
  input wire logic core_req_in,
  input wire logic level_req_in,
  input wire logic pm_cmd_ready_in,
  output logic rails_en_out,
  output logic board_rst_n_out,
  output logic mem_cs_n_out,
  output logic green_led_out,
  output logic blue_led_out,
  output logic enum_n_out,
  output logic enum_oe_n_out,
  output logic pm_cmd_valid_out,
  output logic [1:0] pm_cmd_out,
  output logic early_sw_en_out,
  output logic backup_sw_en_out,
  output logic [5:0] state_out
);

  hsps_pkg::hsps_state_type state_q;
  hsps_pkg::hsps_state_type state_d;
  logic [hsps_pkg::CNT_W-1:0] cnt_q;
  logic [hsps_pkg::CNT_W-1:0] cnt_d;
  logic rails_q;
  logic rails_d;
  logic brst_n_q;
  logic brst_n_d;
  logic cs_n_q;
  logic cs_n_d;
  logic green_q;
  logic green_d;
  logic blue_q;
  logic blue_d;
  logic enum_q;
  logic enum_d;
  logic cmd_v_q;
  logic cmd_v_d;
  logic [1:0] cmd_q;
  logic [1:0] cmd_d;
  logic early_sw;
  logic backup_sw;
  logic early_sw_q;
  logic backup_sw_q;

  localparam logic [hsps_pkg::CNT_W-1:0] SEAT_LAST =
    hsps_pkg::CNT_W'(hsps_pkg::SEAT_DEBOUNCE_CYC - 1);

  // ==========================================================================
  // Supply selector
  // ==========================================================================
  hsps_supply_sel u_sel (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .early_valid_in(early_valid_in),
    .early_sw_en_out(early_sw),
    .backup_sw_en_out(backup_sw)
  );

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rails_d = rails_q;
    enum_d = enum_q;
    cmd_v_d = cmd_v_q;
    cmd_d = cmd_q;
    // A taken command drops its valid.
    if (cmd_v_q && pm_cmd_ready_in)
    begin
      cmd_v_d = 1'b0;
    end
    if (enum_ack_in)
    begin
      enum_d = 1'b0;
    end
    unique case (state_q)
      hsps_pkg::HSPS_ST_EARLY:
      begin
        rails_d = 1'b0;
        cnt_d = '0;
        if (seated_in)
        begin
          state_d = hsps_pkg::HSPS_ST_SEAT;
        end
      end
      hsps_pkg::HSPS_ST_SEAT:
      begin
        if (!seated_in)
        begin
          state_d = hsps_pkg::HSPS_ST_EARLY;
        end
        else if (cnt_q == SEAT_LAST)
        begin
          // Rails turn on through the power module command link.
          rails_d = 1'b1;
          cmd_v_d = 1'b1;
          cmd_d = hsps_pkg::PM_CMD_ON;
          state_d = hsps_pkg::HSPS_ST_RAMP;
        end
        else
        begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      hsps_pkg::HSPS_ST_RAMP:
      begin
        if (power_module_good_in)
        begin
          enum_d = 1'b1;
          state_d = hsps_pkg::HSPS_ST_RUN;
        end
      end
      hsps_pkg::HSPS_ST_RUN:
      begin
        if (!cmd_v_q && core_req_in)
        begin
          cmd_v_d = 1'b1;
          cmd_d = hsps_pkg::PM_CMD_CORE;
        end
        else if (!cmd_v_q && level_req_in)
        begin
          cmd_v_d = 1'b1;
          cmd_d = hsps_pkg::PM_CMD_LEVEL;
        end
        if (swap_switch_in)
        begin
          enum_d = 1'b1;
          state_d = hsps_pkg::HSPS_ST_EXTRACT;
        end
      end
      hsps_pkg::HSPS_ST_EXTRACT:
      begin
        // Host acknowledges once drivers are unloaded; then rails go off.
        if (enum_ack_in && !cmd_v_q)
        begin
          rails_d = 1'b0;
          cmd_v_d = 1'b1;
          cmd_d = hsps_pkg::PM_CMD_OFF;
          state_d = hsps_pkg::HSPS_ST_SAFE;
        end
        else if (enum_ack_in)
        begin
          // A pending command must not use up the only acknowledge; keep asking.
          enum_d = 1'b1;
        end
      end
      hsps_pkg::HSPS_ST_SAFE:
      begin
        if (!seated_in)
        begin
          state_d = hsps_pkg::HSPS_ST_EARLY;
        end
      end
      default:
      begin
        state_d = hsps_pkg::HSPS_ST_EARLY;
      end
    endcase
    if (!clk_en_in)
    begin
      state_d = state_q;
      cnt_d = cnt_q;
      rails_d = rails_q;
      enum_d = enum_q;
      cmd_v_d = cmd_v_q;
      cmd_d = cmd_q;
    end
  end

  // ==========================================================================
  // Output next values
  // ==========================================================================
  always_comb
  begin
    brst_n_d = brst_n_q;
    cs_n_d = cs_n_q;
    green_d = green_q;
    blue_d = blue_q;
    if (clk_en_in)
    begin
      // Module faults drop power good, which pulls board reset, memory select and green LED back.
      brst_n_d = power_module_good_in && !healthy_n_in && pci_rst_n_in
                 && rails_q;
      cs_n_d = mem_cs_n_in || !power_module_good_in;
      green_d = power_module_good_in;
      blue_d = (state_q == hsps_pkg::HSPS_ST_SAFE) && !power_module_good_in;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_in)
  begin
    // Early power onset drives rst_n_in and resets the whole board.
    if (!rst_n_in)
    begin
      state_q <= hsps_pkg::HSPS_ST_EARLY;
      cnt_q <= '0;
      rails_q <= 1'b0;
      enum_q <= 1'b0;
      cmd_v_q <= 1'b0;
      cmd_q <= hsps_pkg::PM_CMD_OFF;
      brst_n_q <= 1'b0;
      cs_n_q <= 1'b1;
      green_q <= 1'b0;
      blue_q <= 1'b0;
      early_sw_q <= 1'b1;
      backup_sw_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rails_q <= rails_d;
      enum_q <= enum_d;
      cmd_v_q <= cmd_v_d;
      cmd_q <= cmd_d;
      brst_n_q <= brst_n_d;
      cs_n_q <= cs_n_d;
      green_q <= green_d;
      blue_q <= blue_d;
      if (clk_en_in)
      begin
        early_sw_q <= early_sw;
        backup_sw_q <= backup_sw;
      end
    end
  end

  assign rails_en_out = rails_q;
  assign board_rst_n_out = brst_n_q;
  assign mem_cs_n_out = cs_n_q;
  assign green_led_out = green_q;
  assign blue_led_out = blue_q;
  // Enumerate is open drain: pulled low by enabling the driver.
  assign enum_n_out = 1'b0;
  assign enum_oe_n_out = ~enum_q;
  assign pm_cmd_valid_out = cmd_v_q;
  assign pm_cmd_out = cmd_q;
  assign early_sw_en_out = early_sw_q;
  assign backup_sw_en_out = backup_sw_q;
  assign state_out = state_q;

endmodule
`default_nettype wire

// ==== dv/hsps_top_props.sv ====
// Assertion checker for the hot-swap power sequencer top level.
`timescale 1ns/1ps
`default_nettype none
module hsps_top_chk (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic seated_in,
  input wire logic power_module_good_in,
  input wire logic healthy_n_in,
  input wire logic pci_rst_n_in,
  input wire logic swap_switch_in,
  input wire logic early_valid_in,
  input wire logic mem_cs_n_in,
  input wire logic pm_cmd_ready_in,
  input wire logic rails_en_out,
  input wire logic board_rst_n_out,
  input wire logic mem_cs_n_out,
  input wire logic green_led_out,
  input wire logic blue_led_out,
  input wire logic enum_oe_n_out,
  input wire logic pm_cmd_valid_out,
  input wire logic [1:0] pm_cmd_out,
  input wire logic early_sw_en_out,
  input wire logic backup_sw_en_out,
  input wire logic [5:0] state_out
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_ev_drop;
    $fell(early_valid_in) && clk_en_in ##1 !early_valid_in && clk_en_in;
  endsequence
  sequence s_ev_back;
    $rose(early_valid_in) && clk_en_in ##1 early_valid_in && clk_en_in;
  endsequence
  a_one_supply: assert property (early_sw_en_out != backup_sw_en_out)
    else $error("supply switches not exclusive");
  a_backup_on_loss: assert property (s_ev_drop |=> backup_sw_en_out)
    else $error("backup power not selected");
  a_early_restore: assert property (s_ev_back |=> early_sw_en_out)
    else $error("early power not restored");
  a_board_rst_gate: assert property ($past(rst_n_in && clk_en_in) |->
    board_rst_n_out ==
    $past(power_module_good_in && !healthy_n_in && pci_rst_n_in && rails_en_out))
    else $error("board reset wrong");
  a_mem_gate: assert property ($past(clk_en_in && !power_module_good_in) |-> mem_cs_n_out)
    else $error("memory select active without power good");
  a_green_good: assert property ($past(rst_n_in && clk_en_in) |-> green_led_out ==
    $past(power_module_good_in))
    else $error("green indicator wrong");
  a_rails_seated: assert property ($rose(rails_en_out) |-> $past(seated_in) &&
    $past(state_out) == 6'h02)
    else $error("rails on without seating");
  a_enum_run: assert property (state_out == 6'h08 && $past(state_out) == 6'h04
    |-> !enum_oe_n_out)
    else $error("enumerate not asserted on insertion");
  a_extract_enum: assert property (state_out == 6'h10 && $past(state_out) == 6'h08
    |-> $past(swap_switch_in) && !enum_oe_n_out)
    else $error("removal not started by switch");
  a_cmd_hold: assert property (pm_cmd_valid_out && !pm_cmd_ready_in
    |=> pm_cmd_valid_out && $stable(pm_cmd_out))
    else $error("command dropped before ready");
  a_blue_safe: assert property (blue_led_out && $past(clk_en_in) |->
    !$past(power_module_good_in) &&
    (state_out == 6'h20 || $past(state_out) == 6'h20))
    else $error("blue indicator lit while unsafe");
  a_freeze_hold: assert property (rst_n_in && !clk_en_in |=> $stable(state_out) &&
    $stable(rails_en_out) && $stable(board_rst_n_out) && $stable(early_sw_en_out))
    else $error("state moved while clock enable low");
endmodule
bind hsps_top hsps_top_chk i_chk (.*);
`default_nettype wire

// ==== dv/hsps_host_model.sv ====
// Power module and system host model facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module hsps_host_model (
  input wire logic clk_in,
  input wire logic rails_en_in,
  input wire logic fault_in,
  input wire logic slow_in,
  input wire logic enum_oe_n_in,
  input wire logic cmd_valid_in,
  output logic good_out = 1'b0,
  output logic ack_out = 1'b0,
  output logic ready_out = 1'b0
);
  int unsigned cnt = 0;
  always @(posedge clk_in)
  begin
    cnt <= rails_en_in ? cnt + 1 : 0;
    good_out <= rails_en_in && !fault_in && cnt > 20;
    ready_out <= cmd_valid_in && !ready_out && (!slow_in || $urandom_range(3) == 0);
    ack_out <= !enum_oe_n_in && !ack_out && cnt[3:0] == 4'h0;
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking testbench for the hot-swap power sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_in = 1'b0;
  logic rst_n = 1'b0;
  logic seated = 1'b0;
  logic healthy_n = 1'b0;
  logic pci_rst_n = 1'b0;
  logic swap = 1'b0;
  logic ev = 1'b1;
  logic cs_n = 1'b1;
  logic core = 1'b0;
  logic level = 1'b0;
  logic fault = 1'b0;
  logic slow = 1'b1;
  logic ce = 1'b1;
  logic good, ack, ready, rails, brst_n, mcs_n, grn, blue, en_n, en_oe_n, vld, esw, bsw;
  logic [1:0] cmd;
  logic [5:0] st;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  bit chk_on = 1'b0;
  bit e_rst, e_cs, e_grn;
  bit ev_q[$] = '{1'b1, 1'b1};
  wire [4:0] w = {rails, st == 6'h08, blue, vld, !vld};
  always #25 sys_clk_in = ~sys_clk_in;
  hsps_top i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n), .clk_en_in(ce),
    .seated_in(seated), .power_module_good_in(good), .healthy_n_in(healthy_n),
    .pci_rst_n_in(pci_rst_n), .swap_switch_in(swap), .enum_ack_in(ack),
    .early_valid_in(ev), .mem_cs_n_in(cs_n), .core_req_in(core), .level_req_in(level),
    .pm_cmd_ready_in(ready), .rails_en_out(rails), .board_rst_n_out(brst_n),
    .mem_cs_n_out(mcs_n), .green_led_out(grn), .blue_led_out(blue), .enum_n_out(en_n),
    .enum_oe_n_out(en_oe_n), .pm_cmd_valid_out(vld), .pm_cmd_out(cmd),
    .early_sw_en_out(esw), .backup_sw_en_out(bsw), .state_out(st));
  hsps_host_model i_host (.clk_in(sys_clk_in), .rails_en_in(rails), .fault_in(fault),
    .slow_in(slow), .enum_oe_n_in(en_oe_n), .cmd_valid_in(vld), .good_out(good),
    .ack_out(ack), .ready_out(ready));
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_for(input int s, input int lim);
    for (n = 0; n < lim && w[s] !== 1'b1; n++)
      @(negedge sys_clk_in);
    if (n == lim)
    begin
      check(1'b0, "timeout");
      finish_test();
    end
  endtask
  // ==========================================================================
  // Reference model of the registered outputs
  // ==========================================================================
  // Registered outputs hold while the clock enable is low; reset still acts.
  always @(posedge sys_clk_in)
    if (ce || !rst_n)
    begin
      e_rst = good && !healthy_n && pci_rst_n && rst_n;
      e_cs = cs_n || !good || !rst_n;
      e_grn = good && rst_n;
      ev_q.push_back(ev || !rst_n);
      void'(ev_q.pop_front());
    end
  always @(negedge sys_clk_in)
    if (rst_n)
    begin
      check(mcs_n === e_cs, "memory select");
      check(grn === e_grn, "green indicator");
      check(esw === ev_q[0] && bsw === !ev_q[0], "supply switches");
      if (chk_on)
        check(brst_n === e_rst, "board reset");
    end
  initial
  begin
    void'($urandom(32'hE96607A3));
    repeat (16) @(posedge sys_clk_in);
    check({rails, brst_n, mcs_n, grn, blue, en_oe_n, vld, cmd, esw, bsw, st, en_n}
      === 18'h09102, "reset values");
    rst_n <= 1'b1;
    pci_rst_n <= 1'b1;
    @(posedge sys_clk_in);
    seated <= 1'b1;
    repeat (1990) @(posedge sys_clk_in);
    seated <= 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check(rails === 1'b0 && st === 6'h01, "rails after short seat");
    @(posedge sys_clk_in);
    seated <= 1'b1;
    wait_for(4, 2100);
    check(n >= 2000 && n <= 2002 && cmd === hsps_pkg::PM_CMD_ON, "rails on");
    chk_on = 1'b1;
    wait_for(3, 100);
    check(en_oe_n === 1'b0, "enumerate on insertion");
    wait_for(0, 50);
    @(posedge sys_clk_in);
    core <= 1'b1;
    level <= 1'b1;
    @(posedge sys_clk_in);
    core <= 1'b0;
    wait_for(1, 50);
    check(cmd === hsps_pkg::PM_CMD_CORE, "core first");
    wait_for(0, 50);
    wait_for(1, 50);
    check(cmd === hsps_pkg::PM_CMD_LEVEL, "level next");
    @(posedge sys_clk_in);
    level <= 1'b0;
    repeat (400)
    begin
      @(posedge sys_clk_in);
      healthy_n <= $urandom_range(3) == 0;
      pci_rst_n <= $urandom_range(7) != 0;
      cs_n <= $urandom_range(1);
      ev <= $urandom_range(15) != 0;
      fault <= $urandom_range(31) == 0;
      slow <= $urandom_range(1);
      ce <= $urandom_range(7) != 0;
    end
    ev <= 1'b1;
    fault <= 1'b0;
    ce <= 1'b1;
    chk_on = 1'b0;
    swap <= 1'b1;
    wait_for(2, 300);
    check(st === 6'h20 && !rails && cmd === hsps_pkg::PM_CMD_OFF, "safe state");
    @(posedge sys_clk_in);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check({rails, brst_n, mcs_n, grn, blue, en_oe_n, vld, cmd, esw, bsw, st, en_n}
      === 18'h09102, "reset in mid-run");
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check(rails === 1'b0 && st === 6'h02, "restart after reset");
    finish_test();
  end
endmodule
`default_nettype wire
